// ---- rtl/plsu_top.sv ----
`timescale 1ns/1ns
`include "plsu_defines.svh"
// Summary of operation
// - shift each halfword left, zero fill
// - saturate overflowed halfword to 0x7FFF/0x8000
// - halfword overflow from discard vector test
// - zero shift passes lane, no overflow
// - halfword result sign-extends from bit 31
// - overflow sets sticky flag bit 22
// - upper lane to bits 31..16
// - quad byte shift by 3-bit amount
// - byte overflow also sets bit 22
// - quad byte result sign-extends from bit 31
// - decode quad byte shift fields
// - variable amount from low four bits
// - decode variable halfword forms
// - decode fixed halfword forms
// - unknown or disabled raises exception, no execution
module plsu_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        issue_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [63:0] source_register,
  input  wire logic [63:0] shift_operand_register,
  input  wire logic        signal_proc_enable,
  output logic             result_valid,
  output logic [63:0]      result_data,
  output logic [4:0]       result_dest,
  output logic             ouflag_set,
  output logic             reserved_instr_exc,
  output logic             signal_proc_disabled_exc,
  output logic             ouflag_bit_reg
);
  logic [63:0] result_reg, result_next;
  logic        valid_reg, ovf_reg, ri_reg, dis_reg;
  logic [4:0]  dest_reg;

  wire [5:0] opc_w = instr_word[`PLSU_OPC_MSB:`PLSU_OPC_LSB];
  wire [5:0] fn_w  = instr_word[`PLSU_FN_MSB:`PLSU_FN_LSB];
  wire [4:0] sub_w = instr_word[`PLSU_SUB_MSB:`PLSU_SUB_LSB];
  wire       cls_ok = (opc_w == `PLSU_OPC_CLASS3) && (fn_w == `PLSU_FN_SHIFT);

  wire dec_qb   = cls_ok && (sub_w == `PLSU_SUB_QB) &&
                  (instr_word[`PLSU_QB_ZERO_MSB:`PLSU_QB_ZERO_LSB] == 2'h0);
  wire ph_zero  = !instr_word[`PLSU_PH_ZERO_BIT];
  wire dec_ph   = cls_ok && ph_zero && (sub_w == `PLSU_SUB_PH);
  wire dec_phs  = cls_ok && ph_zero && (sub_w == `PLSU_SUB_PH_SAT);
  wire dec_vph  = cls_ok && (sub_w == `PLSU_SUB_VPH);
  wire dec_vphs = cls_ok && (sub_w == `PLSU_SUB_VPH_SAT);

  plsu_pkg::plsu_op_t op;
  assign op = dec_qb   ? plsu_pkg::PLSU_OP_QB      :
              dec_ph   ? plsu_pkg::PLSU_OP_PH      :
              dec_phs  ? plsu_pkg::PLSU_OP_PH_SAT  :
              dec_vph  ? plsu_pkg::PLSU_OP_VPH     :
              dec_vphs ? plsu_pkg::PLSU_OP_VPH_SAT : plsu_pkg::PLSU_OP_NONE;

  wire is_var = dec_vph || dec_vphs;
  wire is_sat = dec_phs || dec_vphs;
  // only low four bits of the shift operand count
  wire [3:0] ph_amt = is_var ? shift_operand_register[`PLSU_VAR_SA_MSB:0]
                             : instr_word[`PLSU_PH_SA_MSB:`PLSU_PH_SA_LSB];
  wire [2:0] qb_amt = instr_word[`PLSU_QB_SA_MSB:`PLSU_QB_SA_LSB];

  plsu_lane_if #(.W(16), .SW(4)) hw_if [2] ();
  plsu_lane_if #(.W(8),  .SW(3)) by_if [4] ();

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_hw
      assign hw_if[gi].lane_in  = source_register[16*gi +: 16];
      assign hw_if[gi].amount   = ph_amt;
      assign hw_if[gi].saturate = is_sat;
      plsu_lane_shift #(.W(16), .SW(4)) u_hw (.p(hw_if[gi]));
    end
    for (gi = 0; gi < 4; gi++)
    begin : g_by
      assign by_if[gi].lane_in  = source_register[8*gi +: 8];
      assign by_if[gi].amount   = qb_amt;
      assign by_if[gi].saturate = 1'b0;
      plsu_lane_shift #(.W(8), .SW(3)) u_by (.p(by_if[gi]));
    end
  endgenerate

  wire [31:0] ph_word = {hw_if[1].lane_out, hw_if[0].lane_out};
  wire [31:0] qb_word = {by_if[3].lane_out, by_if[2].lane_out, by_if[1].lane_out, by_if[0].lane_out};
  wire        ph_ovf  = hw_if[1].overflow || hw_if[0].overflow;
  // byte discard vector only tested against zero
  // so a negative byte flags on any nonzero shift, unlike the halfword two-sided test
  wire [7:0]  qb_top  = ~(8'hFF >> ({1'b0, qb_amt} + 4'h1));
  wire [31:0] qb_hit  = source_register[31:0] & {4{qb_top}};
  wire        qb_ovf  = (qb_amt != 3'h0) && (|qb_hit);

  wire known    = (op != plsu_pkg::PLSU_OP_NONE);
  wire exec_ok  = issue_valid && known && signal_proc_enable;
  wire ri_now   = issue_valid && !known;
  wire dis_now  = issue_valid && known && !signal_proc_enable;
  wire ovf_now  = exec_ok && ((op == plsu_pkg::PLSU_OP_QB) ? qb_ovf : ph_ovf);

  always_comb
  begin
    case (op)
      plsu_pkg::PLSU_OP_QB: result_next = {{32{qb_word[31]}}, qb_word};
      plsu_pkg::PLSU_OP_PH, plsu_pkg::PLSU_OP_PH_SAT,
      plsu_pkg::PLSU_OP_VPH, plsu_pkg::PLSU_OP_VPH_SAT:
        result_next = {{32{ph_word[31]}}, ph_word};
      default: result_next = 64'h0000_0000_0000_0000;
    endcase
  end

  // one-step commit of result and flag
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      valid_reg  <= 1'b0;
      result_reg <= 64'h0000_0000_0000_0000;
      dest_reg   <= 5'h00;
      ovf_reg    <= 1'b0;
      ri_reg     <= 1'b0;
      dis_reg    <= 1'b0;
    end
    else if (clk_en)
    begin
      valid_reg  <= exec_ok;
      result_reg <= exec_ok ? result_next : result_reg;
      dest_reg   <= exec_ok ? instr_word[15:11] : dest_reg;
      ovf_reg    <= ovf_now;
      ri_reg     <= ri_now;
      dis_reg    <= dis_now;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ouflag_bit_reg <= 1'b0;
    else if (clk_en && ovf_now)
      ouflag_bit_reg <= 1'b1;
  end

  assign result_valid             = valid_reg;
  assign result_data              = result_reg;
  assign result_dest              = dest_reg;
  assign ouflag_set               = ovf_reg;
  assign reserved_instr_exc       = ri_reg;
  assign signal_proc_disabled_exc = dis_reg;
endmodule

// ---- rtl/plsu_defines.svh ----
`ifndef PLSU_DEFINES_SVH
`define PLSU_DEFINES_SVH

`define PLSU_OPC_MSB        31
`define PLSU_OPC_LSB        26
`define PLSU_OPC_CLASS3     6'h1F
`define PLSU_FN_MSB         5
`define PLSU_FN_LSB         0
`define PLSU_FN_SHIFT       6'h13
`define PLSU_SUB_MSB        10
`define PLSU_SUB_LSB        6
`define PLSU_SUB_QB         5'h00
`define PLSU_SUB_PH         5'h08
`define PLSU_SUB_PH_SAT     5'h0C
`define PLSU_SUB_VPH        5'h0A
`define PLSU_SUB_VPH_SAT    5'h0E
`define PLSU_QB_ZERO_MSB    25
`define PLSU_QB_ZERO_LSB    24
`define PLSU_QB_SA_MSB      23
`define PLSU_QB_SA_LSB      21
`define PLSU_PH_ZERO_BIT    25
`define PLSU_PH_SA_MSB      24
`define PLSU_PH_SA_LSB      21
`define PLSU_VAR_SA_MSB     3
`define PLSU_OUFLAG_BIT     22
`define PLSU_SAT_POS        16'h7FFF
`define PLSU_SAT_NEG        16'h8000

`endif

// ---- rtl/plsu_pkg.sv ----
package plsu_pkg;
  typedef enum logic [2:0]
  {
    PLSU_OP_NONE    = 3'b000,
    PLSU_OP_PH      = 3'b001,
    PLSU_OP_PH_SAT  = 3'b010,
    PLSU_OP_QB      = 3'b011,
    PLSU_OP_VPH     = 3'b100,
    PLSU_OP_VPH_SAT = 3'b101
  } plsu_op_t;
endpackage

// ---- rtl/plsu_lane_if.sv ----
`timescale 1ns/1ns
interface plsu_lane_if #(parameter int W = 16, parameter int SW = 4);
  logic [W-1:0]  lane_in;
  logic [SW-1:0] amount;
  logic          saturate;
  logic [W-1:0]  lane_out;
  logic          overflow;
  modport user (output lane_in, output amount, output saturate, input lane_out, input overflow);
  modport lane (input lane_in, input amount, input saturate, output lane_out, output overflow);
endinterface

// ---- rtl/plsu_lane_shift.sv ----
`timescale 1ns/1ns
`include "plsu_defines.svh"
// one lane: zero-fill left shift, discard-vector overflow, optional saturation
module plsu_lane_shift #(
  parameter int W  = 16,
  parameter int SW = 4
) (
  plsu_lane_if.lane p
);
  initial
  begin
    if (W != (1 << SW))
      $error("lane width must be two to the shift width");
  end

  wire             sign_bit = p.lane_in[W-1];
  wire [W-1:0]     shifted  = p.lane_in << p.amount;
  // bits from the sign downward that leave the lane must all equal the sign
  wire [W-1:0]     top_mask = ~({W{1'b1}} >> p.amount);
  wire [W-1:0]     lost     = p.lane_in & top_mask;
  wire             any_one  = |lost;
  wire             all_one  = (lost == top_mask);
  wire             new_sign = shifted[W-1];
  wire             ovf      = (p.amount != '0) &&
                              ((any_one && !all_one) || (new_sign != sign_bit));
  wire [W-1:0]     sat_val  = sign_bit ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};

  assign p.overflow = ovf;
  assign p.lane_out = (p.saturate && ovf) ? sat_val : shifted;
endmodule

// ---- sim/plsu_gpr_model.sv ----
`timescale 1ns/1ns
module plsu_gpr_model (
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [63:0] wr_data
);
  logic [63:0] regs [32];
  always @(posedge clk) if (wr_en) regs[wr_addr] <= wr_data;
endmodule

// ---- sim/plsu_checker.sv ----
`timescale 1ns/1ns
module plsu_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic        issue_valid,
  input wire logic [31:0] instr_word,
  input wire logic        signal_proc_enable,
  input wire logic        result_valid,
  input wire logic [63:0] result_data,
  input wire logic        ouflag_set,
  input wire logic        reserved_instr_exc,
  input wire logic        signal_proc_disabled_exc,
  input wire logic        ouflag_bit_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic       iss = clk_en && issue_valid;
  wire logic [2:0] ans = {result_valid, reserved_instr_exc, signal_proc_disabled_exc};
  wire logic       qb0 = instr_word[31:21] == 11'h3E0 && instr_word[10:0] == 11'h013;
  a_one_answer: assert property (iss |=> $onehot(ans))
    else $error("not one answer");
  a_idle_quiet: assert property (clk_en && !issue_valid |=> ans == 3'h0 && !ouflag_set)
    else $error("pulse without issue");
  a_off_refuse: assert property (iss && !signal_proc_enable |=> !result_valid && !ouflag_set)
    else $error("ran while disabled");
  a_sign_fill: assert property (result_valid |-> result_data[63:32] == {32{result_data[31]}})
    else $error("upper word not sign");
  a_qb_zero: assert property (iss && signal_proc_enable && qb0 |=> result_valid && !ouflag_set)
    else $error("zero shift flagged");
  a_flag_sticky: assert property (ouflag_bit_reg |=> ouflag_bit_reg) else $error("flag lost");
  a_flag_strobe: assert property (ouflag_set |-> result_valid && ouflag_bit_reg) else $error("stray flag");
  a_flag_cause: assert property ($rose(ouflag_bit_reg) |-> ouflag_set) else $error("flag rose alone");
endmodule
bind plsu_top plsu_checker plsu_checker_inst (.*);

// ---- sim/tb.sv ----
`timescale 1ns/1ns
module tb;
  logic        clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, issue_valid = 1'b0, signal_proc_enable = 1'b0;
  logic        result_valid, ouflag_set, reserved_instr_exc, signal_proc_disabled_exc, ouflag_bit_reg, stk = 1'b0;
  logic [31:0] instr_word = 32'h0, rn, r2;
  logic [63:0] source_register = 64'h0, shift_operand_register = 64'h0, result_data;
  logic [4:0]  result_dest, f5, subs [7] = '{5'h08, 5'h0C, 5'h00, 5'h0E, 5'h0A, 5'h00, 5'h08};
  logic [3:0]  amt;
  logic [4:0]  pd = 5'h00;
  logic [66:0] c, p = 67'h0;
  int          op, miscompares = 0, cmp_count = 0;
  integer      seed = 32'h2dcd;
  wire logic [1:0] pk = p[66:65];
  plsu_top plsu_top_inst (.*);
  plsu_gpr_model plsu_gpr_model_inst (.clk(clk), .wr_en(result_valid), .wr_addr(result_dest), .wr_data(result_data));
  always #5 clk = ~clk;
  task automatic chk(input logic ok);
    cmp_count++;
    miscompares += (ok !== 1'b1);
    if (ok !== 1'b1) $display("[ERR] %0t mismatch", $time);
  endtask
  task automatic results;
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [64:0] exp_fn(input int op, input logic [31:0] s, input logic [3:0] a);
    logic [31:0] r;
    logic [15:0] h;
    logic        f = 1'b0, o;
    for (int l = 0; l < 4 && op == 2; l++)
    begin
      h[7:0] = s[8*l+:8] << a[2:0];
      f |= (a[2:0] != 3'h0) && ((s[8*l+:8] >> (3'h7 - a[2:0])) != 8'h00);
      r[8*l+:8] = h[7:0];
    end
    for (int l = 0; l < 2 && op != 2; l++)
    begin
      h = s[16*l+:16] << a;
      o = $signed(h) >>> a != $signed(s[16*l+:16]);
      f |= o;
      r[16*l+:16] = (o && op[0]) ? (s[16*l+15] ? 16'h8000 : 16'h7FFF) : h;
    end
    return {f, {32{r[31]}}, r};
  endfunction
  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 602; i++)
    begin
      @(posedge clk);
      // first 64 steps pair form i mod 7 with amount i mod 16, then random
      op = (i < 64) ? i % 7 : $unsigned($random(seed)) % 7;
      {r2, rn} = {$random(seed), $random(seed)};
      amt = (i < 64) ? i[3:0] : r2[18:15];
      f5 = (op == 2 || op == 5) ? {1'b0, op == 5, amt[2:0]} : (op == 3 || op == 4) ? r2[14:10] : {op == 6, amt};
      issue_valid <= (i < 600);
      signal_proc_enable <= !(i % 11 == 5 && op < 5);
      source_register <= {r2, rn};
      shift_operand_register <= {rn, r2[31:4], amt};
      instr_word <= {6'h1F, f5, r2[4:0], r2[9:5], subs[op], 6'h13};
      c = {(i >= 600) ? 2'h0 : (op > 4) ? 2'h2 : (i % 11 == 5) ? 2'h3 : 2'h1, exp_fn(op, rn, amt)};
      @(negedge clk);
      stk |= pk == 2'h1 && p[64];
      chk(result_valid === (pk == 2'h1));
      chk(reserved_instr_exc === (pk == 2'h2));
      chk(signal_proc_disabled_exc === (pk == 2'h3));
      chk(ouflag_set === (pk == 2'h1 && p[64]));
      chk(ouflag_bit_reg === stk);
      if (pk == 2'h1) chk(result_data === p[63:0]);
      if (pk == 2'h1) chk(result_dest === pd);
      p = c;
      pd = r2[9:5];
    end
    results;
  end
  initial
  begin
    #20000 miscompares++;
    results;
  end
endmodule
